/* hdl/adcct_map.svh */
`ifndef ADCCT_MAP_SVH
`define ADCCT_MAP_SVH

`define ADCCT_OFF_CTRL 8'h00
`define ADCCT_OFF_PINCFG 8'h04
`define ADCCT_OFF_DIR 8'h08
`define ADCCT_OFF_PORT 8'h0C
`define ADCCT_OFF_RESULT 8'h10
`define ADCCT_OFF_IRQ_STAT 8'h14
`define ADCCT_OFF_IRQ_CLR 8'h18
`define ADCCT_OFF_IRQ_EN 8'h1C

`define ADCCT_CTRL_SEL_LSB 0
`define ADCCT_CTRL_CHAN_LSB 2
`define ADCCT_CTRL_GO_BIT 8

`define ADCCT_SEL_DIV2 2'h0
`define ADCCT_SEL_DIV8 2'h1
`define ADCCT_SEL_DIV32 2'h2
`define ADCCT_SEL_RC 2'h3

`define ADCCT_HALF_DIV2 5'h01
`define ADCCT_HALF_DIV8 5'h04
`define ADCCT_HALF_DIV32 5'h10

`define ADCCT_CONV_HALVES 5'h13
`define ADCCT_GAP_HALVES 3'h4

`define ADCCT_RST_DIR 4'hF
`define ADCCT_RST_PINCFG 4'h0
`define ADCCT_RST_SAR 8'h80

`define ADCCT_RESP_OKAY 2'h0
`define ADCCT_RESP_SLVERR 2'h2

`endif

/* hdl/adcct_pkg.sv */
package adcct_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_GAP} adcct_state_e;
	typedef logic [1:0] adcct_sel_t;
	typedef logic [7:0] adcct_addr_t;
endpackage

/* hdl/adcct_tick_if.sv */
interface adcct_tick_if;
	logic run;
	logic [1:0] sel;
	logic half_tick;
	modport gen(input run, input sel, output half_tick);
	modport user(output run, output sel, input half_tick);
endinterface

/* hdl/adcct_tick.sv */
`include "adcct_map.svh"
module adcct_tick
	import adcct_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic rc_osc,
	adcct_tick_if.gen tk
);
	logic rc_s1_ff;
	logic rc_s2_ff;
	logic rc_s3_ff;
	logic [4:0] cnt_ff;
	logic tick_ff;
	logic [4:0] half_div;

	always_comb begin
		unique case (tk.sel)
			`ADCCT_SEL_DIV2: half_div = `ADCCT_HALF_DIV2;
			`ADCCT_SEL_DIV8: half_div = `ADCCT_HALF_DIV8;
			`ADCCT_SEL_DIV32: half_div = `ADCCT_HALF_DIV32;
			`ADCCT_SEL_RC: half_div = `ADCCT_HALF_DIV2;
		endcase
	end

	// RC oscillator is foreign to clk; third stage only for the edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rc_s1_ff <= 1'b0;
			rc_s2_ff <= 1'b0;
			rc_s3_ff <= 1'b0;
		end else begin
			rc_s1_ff <= rc_osc;
			rc_s2_ff <= rc_s1_ff;
			rc_s3_ff <= rc_s2_ff;
		end
	end

	// Each RC edge is half a bit period, so RC must stay below clk/4
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= 5'h00;
			tick_ff <= 1'b0;
		end else if (!tk.run) begin
			cnt_ff <= 5'h00;
			tick_ff <= 1'b0;
		end else if (tk.sel == `ADCCT_SEL_RC) begin
			cnt_ff <= 5'h00;
			tick_ff <= rc_s2_ff ^ rc_s3_ff;
		end else if (cnt_ff == half_div - 5'h01) begin
			cnt_ff <= 5'h00;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 5'h01;
			tick_ff <= 1'b0;
		end
	end

	assign tk.half_tick = tick_ff;
endmodule

/* hdl/adcct_top.sv */
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`include "adcct_map.svh"
module adcct_top
	import adcct_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rc_osc,
	input wire logic comp_hi,
	input wire logic [3:0] pin_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe,
	output logic [3:0] analog_sel,
	output logic [2:0] mux_channel,
	output logic hold_connect,
	output logic [7:0] dac_code,
	output logic irq,
	output logic wake_req
);
	adcct_tick_if tk();

	logic aw_hold_ff;
	logic w_hold_ff;
	adcct_addr_t awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	adcct_sel_t sel_ff;
	adcct_sel_t conv_sel_ff;
	logic [2:0] chan_ff;
	logic [3:0] pincfg_ff;
	logic [3:0] dir_ff;
	logic [3:0] latch_ff;
	logic [7:0] result_ff;
	logic done_st_ff;
	logic irq_en_ff;
	logic comp_s1_ff;
	logic comp_s2_ff;
	logic [3:0] pin_s1_ff;
	logic [3:0] pin_s2_ff;
	adcct_state_e state_ff;
	adcct_state_e nxt_state;
	logic [4:0] hcnt_ff;
	logic [2:0] gcnt_ff;
	logic [7:0] sar_ff;
	logic hold_ff;
	logic do_wr;
	logic start_req;
	logic done_set;
	logic done_clr;
	logic conv_last;

	function automatic logic addr_hit(input adcct_addr_t a);
		unique case (a)
			`ADCCT_OFF_CTRL, `ADCCT_OFF_PINCFG, `ADCCT_OFF_DIR, `ADCCT_OFF_PORT,
			`ADCCT_OFF_RESULT, `ADCCT_OFF_IRQ_STAT, `ADCCT_OFF_IRQ_CLR, `ADCCT_OFF_IRQ_EN: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	endfunction

	function automatic logic wr_to(input adcct_addr_t a, input logic go, input adcct_addr_t off);
		wr_to = go && (a == off);
	endfunction

	// Next trial code: settle bit idx from the comparator, try the next lower one
	function automatic logic [7:0] sar_step(input logic [7:0] code, input logic [2:0] idx, input logic keep);
		logic [7:0] c;
		c = code;
		c[idx] = keep;
		if (idx != 3'h0) begin
			c[idx - 3'h1] = 1'b1;
		end
		sar_step = c;
	endfunction

	adcct_tick u_tick (
		.clk(clk),
		.resetn(resetn),
		.rc_osc(rc_osc),
		.tk(tk.gen)
	);

	assign tk.run = (state_ff != ST_IDLE);
	assign tk.sel = conv_sel_ff;

	// AXI4-Lite write: address and data taken independently, response after both
	assign s_axi_awready = !aw_hold_ff;
	assign s_axi_wready = !w_hold_ff;
	assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_hold_ff) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_hold_ff <= 1'b0;
			end
			if (s_axi_wvalid && !w_hold_ff) begin
				w_hold_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (do_wr) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `ADCCT_RESP_OKAY;
		end else if (do_wr) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= addr_hit(awaddr_ff) ? `ADCCT_RESP_OKAY : `ADCCT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// Control and pin registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sel_ff <= `ADCCT_SEL_DIV2;
			chan_ff <= 3'h0;
			pincfg_ff <= `ADCCT_RST_PINCFG;
			dir_ff <= `ADCCT_RST_DIR;
			latch_ff <= 4'h0;
			irq_en_ff <= 1'b0;
		end else if (wstrb_ff[0]) begin
			if (wr_to(awaddr_ff, do_wr, `ADCCT_OFF_CTRL)) begin
				sel_ff <= wdata_ff[`ADCCT_CTRL_SEL_LSB +: 2];
				chan_ff <= wdata_ff[`ADCCT_CTRL_CHAN_LSB +: 3];
			end
			if (wr_to(awaddr_ff, do_wr, `ADCCT_OFF_PINCFG)) begin
				pincfg_ff <= wdata_ff[3:0];
			end
			if (wr_to(awaddr_ff, do_wr, `ADCCT_OFF_DIR)) begin
				dir_ff <= wdata_ff[3:0];
			end
			if (wr_to(awaddr_ff, do_wr, `ADCCT_OFF_PORT)) begin
				latch_ff <= wdata_ff[3:0];
			end
			if (wr_to(awaddr_ff, do_wr, `ADCCT_OFF_IRQ_EN)) begin
				irq_en_ff <= wdata_ff[0];
			end
		end
	end

	// Neither channel nor direction takes part in the start decision
	assign start_req = wr_to(awaddr_ff, do_wr, `ADCCT_OFF_CTRL) && wstrb_ff[1] && wdata_ff[`ADCCT_CTRL_GO_BIT];
	assign done_clr = wr_to(awaddr_ff, do_wr, `ADCCT_OFF_IRQ_CLR) && wstrb_ff[0] && wdata_ff[0];

	// Pin inputs come from outside the clock domain
	// Sync delay outruns a two-clock bit period, so DIV2 decisions see the previous trial
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			comp_s1_ff <= 1'b0;
			comp_s2_ff <= 1'b0;
			pin_s1_ff <= 4'h0;
			pin_s2_ff <= 4'h0;
		end else begin
			comp_s1_ff <= comp_hi;
			comp_s2_ff <= comp_s1_ff;
			pin_s1_ff <= pin_in;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign pin_out = latch_ff;
	assign pin_oe = ~dir_ff;
	assign analog_sel = pincfg_ff & dir_ff;
	assign mux_channel = chan_ff;

	// AXI4-Lite read
	assign s_axi_arready = !rvalid_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `ADCCT_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= addr_hit(s_axi_araddr) ? `ADCCT_RESP_OKAY : `ADCCT_RESP_SLVERR;
			unique case (s_axi_araddr)
				`ADCCT_OFF_CTRL: rdata_ff <= {23'h000000, (state_ff != ST_IDLE), 3'h0, chan_ff, sel_ff};
				`ADCCT_OFF_PINCFG: rdata_ff <= {28'h0000000, pincfg_ff};
				`ADCCT_OFF_DIR: rdata_ff <= {28'h0000000, dir_ff};
				`ADCCT_OFF_PORT: rdata_ff <= {28'h0000000, pin_s2_ff & ~pincfg_ff};
				`ADCCT_OFF_RESULT: rdata_ff <= {24'h000000, result_ff};
				`ADCCT_OFF_IRQ_STAT: rdata_ff <= {31'h00000000, done_st_ff};
				`ADCCT_OFF_IRQ_EN: rdata_ff <= {31'h00000000, irq_en_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// Sequencer: acquire in idle, convert, then a disconnected gap
	assign conv_last = tk.half_tick && (hcnt_ff == `ADCCT_CONV_HALVES - 5'h01);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: if (start_req) nxt_state = ST_CONV;
			ST_CONV: if (conv_last) nxt_state = ST_GAP;
			ST_GAP: if (tk.half_tick && gcnt_ff == `ADCCT_GAP_HALVES - 3'h1) nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_IDLE;
			hold_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			hold_ff <= (nxt_state == ST_IDLE);
		end
	end

	assign hold_connect = hold_ff;

	// Source is frozen at start so a select write cannot stretch a conversion
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			conv_sel_ff <= `ADCCT_SEL_DIV2;
		end else if (state_ff == ST_IDLE && start_req) begin
			conv_sel_ff <= sel_ff;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hcnt_ff <= 5'h00;
			gcnt_ff <= 3'h0;
		end else if (state_ff == ST_IDLE) begin
			hcnt_ff <= 5'h00;
			gcnt_ff <= 3'h0;
		end else if (tk.half_tick) begin
			if (state_ff == ST_CONV) begin
				hcnt_ff <= hcnt_ff + 5'h01;
			end else begin
				gcnt_ff <= gcnt_ff + 3'h1;
			end
		end
	end

	// One bit is settled at the end of each of the first eight bit periods
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sar_ff <= `ADCCT_RST_SAR;
		end else if (state_ff == ST_IDLE && start_req) begin
			sar_ff <= `ADCCT_RST_SAR;
		end else if (state_ff == ST_CONV && tk.half_tick && hcnt_ff[0] && hcnt_ff < 5'h10) begin
			sar_ff <= sar_step(sar_ff, 3'h7 - hcnt_ff[3:1], comp_s2_ff);
		end
	end

	assign dac_code = sar_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			result_ff <= 8'h00;
		end else if (state_ff == ST_CONV && conv_last) begin
			result_ff <= sar_ff;
		end
	end

	// Interrupt: a completion in the clearing cycle survives
	assign done_set = (state_ff == ST_CONV) && conv_last;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			done_st_ff <= 1'b0;
		end else begin
			done_st_ff <= done_set || (done_st_ff && !done_clr);
		end
	end

	assign irq = done_st_ff && irq_en_ff;
	assign wake_req = irq && (conv_sel_ff == `ADCCT_SEL_RC);

	chk_hold_gap_open: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff != ST_IDLE) |-> !hold_connect)
		else $error("hold capacitor connected outside acquisition");

	chk_done_result: assert property (@(posedge clk) disable iff (!resetn)
		done_set |=> done_st_ff && (result_ff == $past(sar_ff)) && (state_ff == ST_GAP))
		else $error("completion did not present result and flag");

	chk_conv_halves: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == ST_IDLE && start_req && sel_ff == `ADCCT_SEL_DIV2) |-> ##20 done_set)
		else $error("conversion did not last nineteen half periods");

	chk_gap_halves: assert property (@(posedge clk) disable iff (!resetn)
		(done_set && conv_sel_ff == `ADCCT_SEL_DIV2) |=> !hold_connect [*4] ##1 hold_connect)
		else $error("gap was not two bit periods");

	chk_div8_rate: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == ST_CONV && conv_sel_ff == `ADCCT_SEL_DIV8 && tk.half_tick && hcnt_ff < 5'h11)
		|=> !tk.half_tick [*3] ##1 tk.half_tick)
		else $error("eight-clock bit period wrong");

	chk_div32_rate: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == ST_CONV && conv_sel_ff == `ADCCT_SEL_DIV32 && tk.half_tick && hcnt_ff < 5'h11)
		|-> ##1 !tk.half_tick ##15 tk.half_tick)
		else $error("thirty-two-clock bit period wrong");

	chk_busy_ignore: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == ST_GAP && start_req) |=> state_ff != ST_CONV)
		else $error("start taken during gap");

	chk_start_free: assert property (@(posedge clk) disable iff (!resetn)
		(state_ff == ST_IDLE && start_req) |=> (state_ff == ST_CONV) && (hcnt_ff == 5'h00))
		else $error("start blocked in idle");

	chk_port_mask: assert property (@(posedge clk) disable iff (!resetn)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADCCT_OFF_PORT)
		|=> (s_axi_rdata[3:0] & $past(pincfg_ff)) == 4'h0)
		else $error("analog pin read as nonzero");

	chk_set_wins: assert property (@(posedge clk) disable iff (!resetn)
		(done_set && done_clr) |=> done_st_ff)
		else $error("completion lost to clear");
endmodule

/* bench/adcct_analog_model.sv */
module adcct_analog_model (
	input wire logic clk,
	input wire logic hold_connect,
	input wire logic [2:0] mux_channel,
	input wire logic [7:0] dac_code,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [63:0] levels,
	output logic comp_hi
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] held_ff;
	logic [7:0] in_lvl;
	// A pin that drives shows its own output level to the mux
	always_comb begin
		in_lvl = levels[mux_channel * 8 +: 8];
		if (mux_channel < 3'h4 && pin_oe[mux_channel[1:0]]) begin
			in_lvl = pin_out[mux_channel[1:0]] ? 8'hFF : 8'h00;
		end
	end
	// Ideal capacitor: tracks while connected, keeps its charge otherwise
	always_ff @(posedge clk) begin
		if (hold_connect) begin
			held_ff <= in_lvl;
		end
	end
	assign comp_hi = held_ff >= dac_code;
endmodule

/* bench/tb_adcct_top.sv */
`include "adcct_map.svh"
module tb_adcct_top;
	import adcct_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [63:0] LEVELS = 64'h1DE2A5C3373C964B;
	logic clk, resetn, rc_osc, comp_hi, hold_connect, irq, wake_req;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, dac_code;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, ext_lvl, pin_out, pin_oe, analog_sel;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] mux_channel;
	wire [3:0] pin_in;
	int err_count = 0;
	int num_checks = 0;
	// Wire level: a driven pin shows its latch, the others the outside level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	adcct_top DUT (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rc_osc, .comp_hi, .pin_in, .pin_out, .pin_oe, .analog_sel, .mux_channel,
		.hold_connect, .dac_code, .irq, .wake_req);
	adcct_analog_model partner (.clk, .hold_connect, .mux_channel, .dac_code, .pin_out, .pin_oe,
		.levels(LEVELS), .comp_hi);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Converter oscillator, 8 clocks a period so it stays below clk/4
	initial begin
		rc_osc = 1'b0;
		#230;
		forever #400 rc_osc = ~rc_osc;
	end
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic timeout();
		err_count++;
		$display("wait limit reached at %0t", $time);
		give_verdict();
	endtask
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_rng(input int v, input int lo, input int hi);
		num_checks++;
		if (v < lo || v > hi) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h to %h", $time, v, lo, hi);
		end
	endtask
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) timeout();
		s_axi_bready <= 1'b0;
		check_val({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) timeout();
		s_axi_rready <= 1'b0;
		check_val(s_axi_rdata, ed);
		check_val({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	task automatic t_reset();
		check_val(pin_oe, 32'h0);
		check_val(hold_connect, 32'h1);
		check_val(dac_code, 32'h80);
		rd_chk(`ADCCT_OFF_DIR, 32'hF, 2'h0);
		rd_chk(`ADCCT_OFF_PINCFG, 32'h0, 2'h0);
		rd_chk(`ADCCT_OFF_RESULT, 32'h0, 2'h0);
		rd_chk(`ADCCT_OFF_IRQ_STAT, 32'h0, 2'h0);
		rd_chk(8'h20, 32'h0, 2'h2);
		wr_chk(8'h24, 32'h1, 2'h2);
	endtask
	task automatic t_pins();
		ext_lvl <= 4'hF;
		wr_chk(`ADCCT_OFF_PINCFG, 32'h5, 2'h0);
		wr_chk(`ADCCT_OFF_DIR, 32'hE, 2'h0);
		rd_chk(`ADCCT_OFF_PORT, 32'hA, 2'h0);
		check_val(analog_sel, 32'h4);
		check_val(pin_oe, 32'h1);
	endtask
	task automatic t_conv(input logic [1:0] sel, input logic [2:0] ch, input logic [7:0] ev, input bit poke);
		int h, sl, n;
		time t0;
		h = (sel == 2'h0) ? 1 : (sel == 2'h2) ? 16 : 4;
		sl = (sel == 2'h3) ? 6 : 0;
		wr_chk(`ADCCT_OFF_CTRL, {27'h0, ch, sel}, 2'h0);
		// Let the capacitor settle on the new channel before starting
		repeat (20) @(posedge clk);
		wr_chk(`ADCCT_OFF_CTRL, {23'h0, 1'b1, 3'h0, ch, sel}, 2'h0);
		t0 = $time;
		// A restart on the fastest clock would end far too early
		if (poke) wr_chk(`ADCCT_OFF_CTRL, {23'h0, 1'b1, 3'h0, ch, 2'h0}, 2'h0);
		for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk);
		if (n == 2000) timeout();
		check_rng(int'(($time - t0) / 100), 19 * h - 1 - sl, 19 * h + 5 + sl);
		check_val(hold_connect, 32'h0);
		check_val(wake_req, {31'h0, sel == 2'h3});
		check_val(mux_channel, ch);
		t0 = $time;
		if (poke) wr_chk(`ADCCT_OFF_CTRL, {23'h0, 1'b1, 3'h0, ch, 2'h0}, 2'h0);
		for (n = 0; n < 2000 && hold_connect !== 1'b1; n++) @(posedge clk);
		if (n == 2000) timeout();
		check_rng(int'(($time - t0) / 100), 4 * h - 4 - sl, 4 * h + 3 + sl);
		rd_chk(`ADCCT_OFF_RESULT, {24'h0, ev}, 2'h0);
		wr_chk(`ADCCT_OFF_IRQ_CLR, 32'h1, 2'h0);
		if (poke) begin
			repeat (40) @(posedge clk);
			rd_chk(`ADCCT_OFF_IRQ_STAT, 32'h0, 2'h0);
		end
	endtask
	task automatic t_irq();
		wr_chk(`ADCCT_OFF_CTRL, 32'h0000_0100, 2'h0);
		repeat (40) @(posedge clk);
		check_val(irq, 32'h1);
		wr_chk(`ADCCT_OFF_IRQ_EN, 32'h0, 2'h0);
		check_val(irq, 32'h0);
		rd_chk(`ADCCT_OFF_IRQ_STAT, 32'h1, 2'h0);
		rd_chk(`ADCCT_OFF_IRQ_CLR, 32'h0, 2'h0);
		wr_chk(`ADCCT_OFF_IRQ_CLR, 32'h1, 2'h0);
		rd_chk(`ADCCT_OFF_IRQ_STAT, 32'h0, 2'h0);
		wr_chk(`ADCCT_OFF_IRQ_EN, 32'h1, 2'h0);
		check_val(irq, 32'h0);
		// Clear executes on the completion cycle of a DIV2 run; the new flag must stay
		wr_chk(`ADCCT_OFF_CTRL, 32'h0000_0100, 2'h0);
		repeat (16) @(posedge clk);
		wr_chk(`ADCCT_OFF_IRQ_CLR, 32'h1, 2'h0);
		check_val(irq, 32'h1);
	endtask
	initial begin
		resetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		ext_lvl = 4'h0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_pins();
		wr_chk(`ADCCT_OFF_IRQ_EN, 32'h1, 2'h0);
		// Only the thirty-two-clock source reaches the 1.6 us floor at this clock
		t_conv(2'h2, 3'h1, 8'h96, 1'b0);
		t_conv(2'h1, 3'h5, 8'hA5, 1'b1);
		t_conv(2'h2, 3'h2, 8'h3C, 1'b0);
		// RC above 1 MHz is out of spec; the ideal model masks the accuracy loss
		t_conv(2'h3, 3'h3, 8'h37, 1'b0);
		wr_chk(`ADCCT_OFF_PORT, 32'h1, 2'h0);
		// Driven-high pin: a rail level is immune to the late DIV2 comparator
		t_conv(2'h0, 3'h0, 8'hFF, 1'b0);
		t_irq();
		give_verdict();
	end
endmodule
